// file: core/chdly_top.sv
// Purpose: forwards a sample stream to a result channel with a programmable delay
// Assumes: STB_I marks one update cycle; inputs come from logic on CLK_I
// Notes: delay range 0..DEPTH; larger settings are clamped to DEPTH
// Overview of operation
// - each sample leaves unchanged after the configured number of update cycles
// - delay is an integer count; one step adds one sample period
// - at 19200 Hz update rate, one step adds 52.08 us
// - delay zero forwards the sample in the same update cycle
// - invalid input always produces invalid output
// - invalid input empties the whole delay buffer
// - output stays invalid until buffer refilled with a full delay of valid samples
`timescale 1ns/1ps
module chdly_top (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic SRST_I,
  input wire logic STB_I,
  input wire logic [chdly_pkg::DLY_W-1:0] DELAY_I,
  input wire chdly_pkg::sample_t SAMPLE_I,
  output chdly_pkg::sample_t SAMPLE_O,
  output logic STB_O
);
  localparam logic [chdly_pkg::DLY_W-1:0] MAX_DLY = chdly_pkg::DLY_W'(chdly_pkg::DEPTH);
  localparam logic [chdly_pkg::PTR_W-1:0] PTR_ONE = 6'h01;
  localparam logic [chdly_pkg::DLY_W-1:0] DLY_ONE = 7'h01;

  typedef enum logic {ST_FILL, ST_RUN} state_t;

  state_t state_reg, state_next;
  logic [chdly_pkg::PTR_W-1:0] wptr_reg, wptr_next;
  logic [chdly_pkg::DLY_W-1:0] fill_reg, fill_next;
  logic [chdly_pkg::DLY_W-1:0] delay_reg, delay_next;
  chdly_pkg::sample_t out_reg, out_next;
  logic stb_reg, stb_next;
  logic [chdly_pkg::DLY_W-1:0] dly_eff;
  logic [chdly_pkg::PTR_W-1:0] rd_addr;
  logic [chdly_pkg::SAMPLE_W-1:0] rd_data;
  logic wr_en;

  // delay clamped so the read pointer never laps the writer
  assign dly_eff = (DELAY_I > MAX_DLY) ? MAX_DLY : DELAY_I;
  // oldest entry sits dly_eff slots behind the write pointer
  assign rd_addr = wptr_reg - dly_eff[chdly_pkg::PTR_W-1:0];
  assign wr_en = STB_I && SAMPLE_I.valid && !SRST_I;

  chdly_mem u_mem (
    .clk_i(CLK_I),
    .wr_en_i(wr_en),
    .wr_addr_i(wptr_reg),
    .wr_data_i(SAMPLE_I.data),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data)
  );

  always_comb begin
    state_next = state_reg;
    wptr_next = wptr_reg;
    fill_next = fill_reg;
    delay_next = delay_reg;
    out_next = out_reg;
    stb_next = 1'b0;
    if (SRST_I) begin
      state_next = ST_FILL;
      wptr_next = chdly_pkg::PTR_RST;
      fill_next = chdly_pkg::FILL_RST;
      delay_next = chdly_pkg::DELAY_RST;
      out_next = '0;
    end else if (STB_I) begin
      stb_next = 1'b1;
      delay_next = dly_eff;
      // a changed delay restarts the fill so no stale slot is ever read
      if (dly_eff != delay_reg) begin
        fill_next = chdly_pkg::FILL_RST;
        state_next = ST_FILL;
      end
      if (!SAMPLE_I.valid) begin
        out_next.valid = 1'b0;
        out_next.data = SAMPLE_I.data;
        fill_next = chdly_pkg::FILL_RST;
        state_next = ST_FILL;
      end else if (dly_eff == '0) begin
        out_next = SAMPLE_I;
        state_next = ST_RUN;
      end else begin
        wptr_next = wptr_reg + PTR_ONE;
        if ((dly_eff == delay_reg) && (state_reg == ST_RUN)) begin
          out_next.valid = 1'b1;
          out_next.data = rd_data;
        end else begin
          out_next.valid = 1'b0;
          out_next.data = chdly_pkg::DATA_RST;
          if (fill_next == dly_eff - DLY_ONE) begin
            state_next = ST_RUN;
          end else begin
            fill_next = fill_next + DLY_ONE;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= ST_FILL;
      wptr_reg <= chdly_pkg::PTR_RST;
      fill_reg <= chdly_pkg::FILL_RST;
      delay_reg <= chdly_pkg::DELAY_RST;
      out_reg <= '0;
      stb_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wptr_reg <= wptr_next;
      fill_reg <= fill_next;
      delay_reg <= delay_next;
      out_reg <= out_next;
      stb_reg <= stb_next;
    end
  end

  assign SAMPLE_O = out_reg;
  assign STB_O = stb_reg;

  // checker-only history: data of the most recent accepted valid sample,
  // so the one-step check does not lean on the buffer read path it guards
  logic [chdly_pkg::SAMPLE_W-1:0] prev_data_reg, prev_data_next;

  always_comb begin
    prev_data_next = prev_data_reg;
    if (STB_I && !SRST_I && SAMPLE_I.valid) begin
      prev_data_next = SAMPLE_I.data;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prev_data_reg <= chdly_pkg::DATA_RST;
    end else begin
      prev_data_reg <= prev_data_next;
    end
  end

  property p_invalid_passes;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (STB_I && !SRST_I && !SAMPLE_I.valid) |=> (STB_O && !SAMPLE_O.valid);
  endproperty
  a_invalid_passes: assert property (p_invalid_passes) else $error("invalid input gave valid output");

  property p_zero_delay;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (STB_I && !SRST_I && SAMPLE_I.valid && DELAY_I == '0) |=> (SAMPLE_O.valid && SAMPLE_O.data == $past(SAMPLE_I.data));
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not forward sample");

  property p_flush;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (STB_I && !SRST_I && !SAMPLE_I.valid) |=> (fill_reg == '0 && state_reg == ST_FILL);
  endproperty
  a_flush: assert property (p_flush) else $error("buffer not flushed on invalid input");

  property p_strobe;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (STB_I && !SRST_I) |=> STB_O;
  endproperty
  a_strobe: assert property (p_strobe) else $error("output strobe missing");

  property p_first_after_flush;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (STB_I && !SRST_I && !SAMPLE_I.valid) ##1 (STB_I && !SRST_I && SAMPLE_I.valid && DELAY_I != '0)
        |=> !SAMPLE_O.valid;
  endproperty
  a_first_after_flush: assert property (p_first_after_flush) else $error("valid before refill");

  property p_one_step;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (state_reg == ST_RUN && STB_I && !SRST_I && SAMPLE_I.valid && DELAY_I == DLY_ONE && delay_reg == DLY_ONE)
        |=> (SAMPLE_O.valid && SAMPLE_O.data == $past(prev_data_reg));
  endproperty
  a_one_step: assert property (p_one_step) else $error("one step delay wrong");

  property p_fill_bound;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (fill_reg == '0) || (fill_reg < delay_reg);
  endproperty
  a_fill_bound: assert property (p_fill_bound) else $error("fill count out of range");

  property p_srst;
    @(posedge CLK_I) disable iff (!RSTN_I)
      SRST_I |=> (delay_reg == '0 && fill_reg == '0 && !STB_O);
  endproperty
  a_srst: assert property (p_srst) else $error("sync reset did not clear");

  property p_strobe_pulse;
    @(posedge CLK_I) disable iff (!RSTN_I)
      !(STB_I && !SRST_I) |=> !STB_O;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("output strobe without input strobe");

  // result channel must hold its value between update cycles
  property p_hold;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (!STB_I && !SRST_I) |=> $stable(SAMPLE_O);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed between strobes");

  property p_delay_clamp;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (STB_I && !SRST_I && DELAY_I > MAX_DLY) |=> (delay_reg == MAX_DLY);
  endproperty
  a_delay_clamp: assert property (p_delay_clamp) else $error("delay above depth not clamped");

  property p_delay_taken;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (STB_I && !SRST_I && DELAY_I <= MAX_DLY) |=> (delay_reg == $past(DELAY_I));
  endproperty
  a_delay_taken: assert property (p_delay_taken) else $error("delay setting not taken");

  // every strobe at a non-zero delay seen while refilling must leave the output invalid
  property p_fill_invalid;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (state_reg == ST_FILL && STB_I && !SRST_I && DELAY_I != '0) |=> !SAMPLE_O.valid;
  endproperty
  a_fill_invalid: assert property (p_fill_invalid) else $error("valid output while refilling");

  property p_srst_clear;
    @(posedge CLK_I) disable iff (!RSTN_I)
      SRST_I |=> (state_reg == ST_FILL && wptr_reg == chdly_pkg::PTR_RST && !SAMPLE_O.valid);
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("sync reset left buffer state");
endmodule : chdly_top

// file: core/chdly_pkg.sv
// Purpose: shared constants and types for the channel delay line
// Assumes: one update cycle per sample strobe
// Notes: sample width and buffer depth fixed
package chdly_pkg;
  localparam int SAMPLE_W = 32;
  localparam int DEPTH = 64;
  localparam int DLY_W = 7;
  localparam int PTR_W = 6;
  localparam int UPDATE_RATE_HZ = 19200;
  localparam real CYCLE_US = 52.08;
  localparam logic [DLY_W-1:0] DELAY_RST = 7'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic [DLY_W-1:0] FILL_RST = 7'h00;
  localparam logic [SAMPLE_W-1:0] DATA_RST = 32'h00000000;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } sample_t;
endpackage : chdly_pkg

// file: core/chdly_mem.sv
// Purpose: sample storage for the delay line
// Assumes: single write and single read port, same clock
// Notes: read is combinational; no reset needed on the array contents
`timescale 1ns/1ps
module chdly_mem (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [chdly_pkg::PTR_W-1:0] wr_addr_i,
  input wire logic [chdly_pkg::SAMPLE_W-1:0] wr_data_i,
  input wire logic [chdly_pkg::PTR_W-1:0] rd_addr_i,
  output logic [chdly_pkg::SAMPLE_W-1:0] rd_data_o
);
  logic [chdly_pkg::SAMPLE_W-1:0] mem [chdly_pkg::DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_addr_i];
endmodule : chdly_mem

// file: tb/chdly_src.sv
// Purpose: upstream sample producer for the delay line
// Assumes: one strobe per send, lines change just after an edge
// Notes: lines are scrambled after the strobe so stale data is never seen
`timescale 1ns/1ps
module chdly_src (
  input wire logic clk_i,
  output logic stb_o,
  output chdly_pkg::sample_t sample_o
);
  initial begin
    stb_o = 1'b0;
    sample_o = '0;
  end
  task automatic send(input logic v, input logic [chdly_pkg::SAMPLE_W-1:0] d);
    @(posedge clk_i);
    stb_o <= 1'b1;
    sample_o <= {v, d};
    @(posedge clk_i);
    stb_o <= 1'b0;
    sample_o <= ~sample_o;
  endtask : send
  // two strobes on consecutive edges; strobe stays up between them
  task automatic send_pair(input logic v0, input logic [chdly_pkg::SAMPLE_W-1:0] d0,
                           input logic v1, input logic [chdly_pkg::SAMPLE_W-1:0] d1);
    @(posedge clk_i);
    stb_o <= 1'b1;
    sample_o <= {v0, d0};
    @(posedge clk_i);
    sample_o <= {v1, d1};
    @(posedge clk_i);
    stb_o <= 1'b0;
    sample_o <= ~sample_o;
  endtask : send_pair
endmodule : chdly_src

// file: tb/chdly_top_bench.sv
// Purpose: self-checking bench for the channel delay line
// Assumes: one update cycle per producer strobe
// Notes: expected stream is rebuilt from a fill counter and a history queue
`timescale 1ns/1ps
module chdly_top_bench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic srst_i = 1'b0;
  logic stb_i, stb_o;
  logic [chdly_pkg::DLY_W-1:0] delay_i = 7'h00;
  chdly_pkg::sample_t sample_i, sample_o;
  int n_fail = 0, check_count = 0, cycles = 0, fill = 0, dly = 0;
  logic [chdly_pkg::SAMPLE_W-1:0] hist[$];
  chdly_top u_chdly_top (.CLK_I(clk_i), .RSTN_I(rstn_i), .SRST_I(srst_i), .STB_I(stb_i),
    .DELAY_I(delay_i), .SAMPLE_I(sample_i), .SAMPLE_O(sample_o), .STB_O(stb_o));
  chdly_src u_chdly_src (.clk_i(clk_i), .stb_o(stb_i), .sample_o(sample_i));
  initial forever #2 clk_i = ~clk_i;
  // a hang would otherwise hide every later mismatch
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // the model keeps its own delay copy: delay_i only settles after the edge
  task automatic restart(input logic [chdly_pkg::DLY_W-1:0] d);
    int eff;
    eff = (int'(d) > chdly_pkg::DEPTH) ? chdly_pkg::DEPTH : int'(d);
    @(posedge clk_i);
    delay_i <= d;
    if (eff != dly) begin
      fill = 0;
      hist.delete();
    end
    dly = eff;
  endtask : restart
  task automatic model(input logic v, input logic [chdly_pkg::SAMPLE_W-1:0] d,
                       output logic ev, output logic [chdly_pkg::SAMPLE_W-1:0] ed);
    ev = 1'b0;
    ed = d;
    if (!v) begin
      fill = 0;
      hist.delete();
    end else begin
      hist.push_back(d);
      if (fill < dly) fill++;
      else begin
        ev = 1'b1;
        ed = hist.pop_front();
      end
    end
  endtask : model
  task automatic judge(input logic ev, input logic [chdly_pkg::SAMPLE_W-1:0] ed);
    check_count++;
    if (stb_o !== 1'b1 || sample_o.valid !== ev || (ev && sample_o.data !== ed)) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, sample_o, {ev, ed});
    end
  endtask : judge
  task automatic send_chk(input logic v, input logic [chdly_pkg::SAMPLE_W-1:0] d);
    logic ev;
    logic [chdly_pkg::SAMPLE_W-1:0] ed;
    model(v, d, ev, ed);
    u_chdly_src.send(v, d);
    #1;
    judge(ev, ed);
  endtask : send_chk
  task automatic pair_chk(input logic v0, input logic [chdly_pkg::SAMPLE_W-1:0] d0,
                          input logic v1, input logic [chdly_pkg::SAMPLE_W-1:0] d1);
    logic ev0, ev1;
    logic [chdly_pkg::SAMPLE_W-1:0] ed0, ed1;
    model(v0, d0, ev0, ed0);
    model(v1, d1, ev1, ed1);
    fork
      u_chdly_src.send_pair(v0, d0, v1, d1);
      begin
        repeat (2) @(posedge clk_i);
        #1;
        judge(ev0, ed0);
        @(posedge clk_i);
        #1;
        judge(ev1, ed1);
      end
    join
  endtask : pair_chk
  task automatic t_default();
    send_chk(1'b1, 32'h1234abcd);
  endtask : t_default
  task automatic t_delay_two();
    restart(7'h02);
    for (int i = 0; i < 5; i++) send_chk(1'b1, 32'ha0000000 + i);
  endtask : t_delay_two
  task automatic t_flush();
    restart(7'h03);
    for (int i = 0; i < 4; i++) send_chk(1'b1, 32'hb0000000 + i);
    send_chk(1'b0, 32'h5a5a5a5a);
    for (int i = 0; i < 5; i++) send_chk(1'b1, 32'hc0000000 + i);
  endtask : t_flush
  task automatic t_max_delay();
    restart(7'h40);
    for (int i = 0; i < 66; i++) send_chk(1'b1, 32'hd0000000 + i);
    restart(7'h7f);
    for (int i = 66; i < 69; i++) send_chk(1'b1, 32'hd0000000 + i);
  endtask : t_max_delay
  task automatic t_sync_clear();
    restart(7'h01);
    send_chk(1'b1, 32'he0000001);
    @(posedge clk_i);
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    fill = 0;
    hist.delete();
    for (int i = 0; i < 3; i++) send_chk(1'b1, 32'hf0000000 + i);
  endtask : t_sync_clear
  task automatic t_back_to_back();
    restart(7'h02);
    for (int i = 0; i < 3; i++) send_chk(1'b1, 32'h90000000 + i);
    pair_chk(1'b0, 32'h5a5a0000, 1'b1, 32'h91000000);
    pair_chk(1'b1, 32'h91000001, 1'b1, 32'h91000002);
  endtask : t_back_to_back
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_default();
    t_delay_two();
    t_flush();
    t_max_delay();
    t_sync_clear();
    t_back_to_back();
    finish_test();
  end
endmodule : chdly_top_bench
